/* logic/perf_event_select_decoder.v */
`timescale 1ns/1ps
`include "perf_event_consts.vh"
module perf_event_select_decoder #(
   parameter PENALTY_W = 4
) (
   // clock and reset
   input  wire       clock,
   input  wire       rst,
   // event selection from the counter control
   input  wire [7:0] event_select,
   input  wire [7:0] unit_mask,
   // load retirement
   input  wire       load_retired,
   input  wire       load_xlat_miss,
   input  wire       load_fault,
   // vector unit
   input  wire       mm_state_dirty,
   input  wire       mm_clear_exec,
   input  wire       vec_denormal_in,
   input  wire       vec_underflow,
   input  wire       denormals_as_zero_flag,
   input  wire       flush_to_zero_flag,
   input  wire       vector_retired,
   input  wire       vector_saturating,
   // front end
   input  wire       branch_decoded,
   input  wire       false_branch_detect,
   input  wire       frontend_predict_fix,
   // counter side
   output reg        count_increment,
   output reg        retired_load_xlat_miss,
   output reg        vector_assist_count,
   output reg        vector_instr_retired_count,
   output reg        vector_saturating_retired_count,
   output reg        branch_decoded_count,
   output reg        false_branch_count,
   output reg        frontend_redirect_count,
   // effects on the front end
   output reg        branch_target_buffer_flush,
   output wire       frontend_stall
);
   // timing, seen from the counter side:
   // - every input is a one-cycle pulse from the pipeline, taken at the
   //   rising edge it stands on; levels (dirty state, the two corner
   //   flags) are read in that same cycle
   // - every output pulse appears exactly one cycle later, from a flop,
   //   so the counter never sees a combinational glitch on a select change
   // - the cost is one cycle of latency on every event; a counter that is
   //   read back in software never notices it
   // - changing the selection in mid-run is safe: the pulse of the cycle
   //   in which the change lands belongs to the new selection
   //
   // per-event outputs:
   // - each listed event also has its own pulse, independent of the
   //   selection, so a second counter or a trace unit can watch it
   // - an unlisted selection silences only the selected pulse, never the
   //   per-event ones
   //
   // merging:
   // - sources of one event that fire in one cycle count once; the
   //   pipeline cannot report two loads or two redirects in one cycle
   //   through these pins, so nothing is lost by that
   // - a false branch is a redirect as well, so the redirect event and
   //   the stall model both see it
   //
   // limitations:
   // - there is no running count here; the counter registers, their
   //   control and overflow live outside this block
   // - the stall output is a model of the redirect cost, not a pipeline
   //   hold; its length is a fixed approximation from the header
   // - back-to-back redirects restart the stall window instead of
   //   stacking, which under-reports bursts but keeps the counter narrow
   // raw occurrence terms for the load, assist and redirect events
   // raw occurrence terms for the load, assist and redirect events
   wire occ_xlat;        // retired load missed translation
   wire occ_assist;      // vector assist raised
   wire occ_redirect;    // any front-end redirect
   wire sel_hit;         // selection names a listed event
   reg  next_increment;  // chosen occurrence for the counter
   // selection decode, one term per listed pair
   wire sel_load;        // cb with the translation-miss mask
   wire sel_assist;      // cd with no mask bits
   wire sel_vec_ret;     // ce with no mask bits
   wire sel_vec_sat;     // cf with no mask bits
   wire sel_br_dec;      // e0 with mask one
   wire sel_false_br;    // e4 with mask one
   wire sel_redirect;    // e6 with mask one

   // each pair must match in full; a stray mask bit drops the selection
   assign sel_load     = (event_select == `EVT_LOAD_RETIRED) &
                         (unit_mask == `UMASK_XLAT_MISS);
   assign sel_assist   = (event_select == `EVT_VECTOR_ASSIST) &
                         (unit_mask == `UMASK_NONE);
   assign sel_vec_ret  = (event_select == `EVT_VECTOR_RETIRED) &
                         (unit_mask == `UMASK_NONE);
   assign sel_vec_sat  = (event_select == `EVT_VECTOR_SAT) &
                         (unit_mask == `UMASK_NONE);
   assign sel_br_dec   = (event_select == `EVT_BRANCH_DECODED) &
                         (unit_mask == `UMASK_ONE);
   assign sel_false_br = (event_select == `EVT_FALSE_BRANCH) &
                         (unit_mask == `UMASK_ONE);
   assign sel_redirect = (event_select == `EVT_FRONTEND_REDIRECT) &
                         (unit_mask == `UMASK_ONE);

   // no listed pair matched: the counter must see nothing
   assign sel_hit = sel_load | sel_assist | sel_vec_ret | sel_vec_sat
                  | sel_br_dec | sel_false_br | sel_redirect;

   // a faulting load never reaches the count even on a miss
   assign occ_xlat = load_retired & load_xlat_miss & ~load_fault;

   // assists from state clear and from unflushed corner operands
   assign occ_assist = (mm_clear_exec & mm_state_dirty)
                     | (vec_denormal_in & ~denormals_as_zero_flag)
                     | (vec_underflow & ~flush_to_zero_flag);

   // a false branch is itself a redirect, so both sources merge here
   assign occ_redirect = frontend_predict_fix | false_branch_detect;

   // select the occurrence that matches the programmed pair
   always @* begin
      next_increment = 1'b0;
      // the pairs are disjoint, so the chain order carries no priority
      if (sel_load) begin
         // loads that faulted are already out of occ_xlat
         next_increment = occ_xlat;
      end else if (sel_assist) begin
         // any of the three assist causes
         next_increment = occ_assist;
      end else if (sel_vec_ret) begin
         // every retiring vector instruction
         next_increment = vector_retired;
      end else if (sel_vec_sat) begin
         // the qualifier alone never counts
         next_increment = vector_retired & vector_saturating;
      end else if (sel_br_dec) begin
         // one pulse per decoded branch
         next_increment = branch_decoded;
      end else if (sel_false_br) begin
         // only the false detections, not ordinary redirects
         next_increment = false_branch_detect;
      end else if (sel_redirect) begin
         // every redirect, false branches included
         next_increment = occ_redirect;
      end else begin
         // unlisted pair: stay silent
         next_increment = 1'b0;
      end
   end

   // registered pulses; one cycle of latency keeps outputs glitch free
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count_increment                 <= 1'b0;
         retired_load_xlat_miss          <= 1'b0;
         vector_assist_count             <= 1'b0;
         vector_instr_retired_count      <= 1'b0;
         vector_saturating_retired_count <= 1'b0;
         branch_decoded_count            <= 1'b0;
         false_branch_count              <= 1'b0;
         frontend_redirect_count         <= 1'b0;
         branch_target_buffer_flush      <= 1'b0;
      end else begin
         // second guard so a decode slip cannot leak a pulse
         count_increment                 <= next_increment & sel_hit;
         retired_load_xlat_miss          <= occ_xlat;
         vector_assist_count             <= occ_assist;
         vector_instr_retired_count      <= vector_retired;
         vector_saturating_retired_count <= vector_retired & vector_saturating;
         branch_decoded_count            <= branch_decoded;
         false_branch_count              <= false_branch_detect;
         frontend_redirect_count         <= occ_redirect;
         branch_target_buffer_flush      <= false_branch_detect;
      end
   end

   // stall model for the redirect cost; figure is only approximate
   redirect_penalty #(
      .CW (PENALTY_W)
   ) u_penalty (
      .clock  (clock),
      .rst    (rst),
      .start  (occ_redirect),
      .length (`REDIRECT_PENALTY_CYC),
      .stall  (frontend_stall)
   );
endmodule // perf_event_select_decoder

/* logic/perf_event_consts.vh */
`ifndef PERF_EVENT_CONSTS_VH
`define PERF_EVENT_CONSTS_VH

// event numbers
`define EVT_LOAD_RETIRED      8'hcb
`define EVT_VECTOR_ASSIST     8'hcd
`define EVT_VECTOR_RETIRED    8'hce
`define EVT_VECTOR_SAT        8'hcf
`define EVT_BRANCH_DECODED    8'he0
`define EVT_FALSE_BRANCH      8'he4
`define EVT_FRONTEND_REDIRECT 8'he6

// unit masks
`define UMASK_XLAT_MISS       8'h04
`define UMASK_NONE            8'h00
`define UMASK_ONE             8'h01

// redirect penalty, approximate
`define REDIRECT_PENALTY_CYC  4'h7

// reset values
`define RESET_BYTE            8'h00

`endif

/* logic/redirect_penalty.v */
`timescale 1ns/1ps
// approximate front-end stall after a redirect
module redirect_penalty #(
   parameter CW = 4
) (
   // clock and reset
   input  wire          clock,
   input  wire          rst,
   // redirect trigger
   input  wire          start,
   input  wire [CW-1:0] length,
   // stall indication
   output reg           stall
);
   reg [CW-1:0] remain;   // cycles left in the stall window

   // a new redirect restarts the window; back-to-back ones do not stack
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         remain <= {CW{1'b0}};
         stall  <= 1'b0;
      end else if (start) begin
         remain <= length;
         stall  <= (length != {CW{1'b0}});
      end else if (remain != {CW{1'b0}}) begin
         remain <= remain - {{(CW-1){1'b0}}, 1'b1};
         stall  <= (remain > {{(CW-1){1'b0}}, 1'b1});
      end else begin
         stall <= 1'b0;
      end
   end
endmodule // redirect_penalty

/* verif/pipeline_model.sv */
`timescale 1ns/1ps
// pipeline side: each requested pulse is shown for one cycle
module pipeline_model (
   // clock and pulse requests
   input  wire        clock,
   input  wire [10:0] fire,
   // event pulses toward the decoder
   output reg  [10:0] pulse
);
   // launched on the falling edge, clear of the sampling edge
   always @(negedge clock) pulse <= fire;
endmodule // pipeline_model

/* verif/perf_event_monitor.sv */
`timescale 1ns/1ps
// event pulses are tied to their causes one cycle earlier
module perf_event_monitor (
   input wire clock, rst,
   input wire [7:0] event_select, unit_mask,
   input wire load_retired, load_xlat_miss, load_fault, mm_state_dirty,
   input wire mm_clear_exec, vec_denormal_in, vec_underflow,
   input wire denormals_as_zero_flag, flush_to_zero_flag, vector_retired,
   input wire vector_saturating, branch_decoded, false_branch_detect,
   input wire frontend_predict_fix, count_increment, retired_load_xlat_miss,
   input wire vector_assist_count, vector_instr_retired_count,
   input wire vector_saturating_retired_count, branch_decoded_count,
   input wire false_branch_count, frontend_redirect_count,
   input wire branch_target_buffer_flush, frontend_stall
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // a redirect cause, then its count and the stall it holds
   sequence s_redir; frontend_predict_fix || false_branch_detect; endsequence
   sequence s_stall; frontend_redirect_count ##0 frontend_stall [*7];
   endsequence
   chk_load_miss: assert property (load_retired && load_xlat_miss
      |=> retired_load_xlat_miss == !$past(load_fault)) else $error("load");
   chk_vec_assist: assert property ((mm_clear_exec && mm_state_dirty)
      || (vec_denormal_in && !denormals_as_zero_flag) || (vec_underflow
      && !flush_to_zero_flag) |=> vector_assist_count) else $error("assist");
   chk_vec_ret: assert property (vector_retired
      |=> vector_instr_retired_count) else $error("vector retired");
   chk_vec_sat: assert property (vector_retired && vector_saturating
      |=> vector_saturating_retired_count) else $error("saturating");
   chk_br_dec: assert property (branch_decoded
      |=> branch_decoded_count) else $error("decoded branch");
   chk_false_br: assert property (false_branch_detect |=> false_branch_count
      && branch_target_buffer_flush) else $error("false branch");
   chk_redir_stall: assert property (s_redir |=> s_stall)
      else $error("redirect stall");
   chk_unlisted_sel: assert property (event_select == 8'hff
      |=> !count_increment) else $error("unlisted pulse");
endmodule // perf_event_monitor
bind perf_event_select_decoder perf_event_monitor mon (.*);

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   reg         clock = 1'b0, rst = 1'b1;   // core clock, async reset
   reg  [7:0]  event_select = 8'h00, unit_mask = 8'h00; // selection
   reg  [10:0] fire = 11'h000;  // requests to the pipeline model
   reg  [2:0]  lv = 3'h0;       // dirty, denormal-zero, flush-zero levels
   wire [10:0] p;               // pulses from the pipeline model
   wire count_increment, retired_load_xlat_miss, vector_assist_count,
      vector_instr_retired_count, vector_saturating_retired_count,
      branch_decoded_count, false_branch_count, frontend_redirect_count,
      branch_target_buffer_flush, frontend_stall;
   integer miscompares = 0, n_checks = 0, cyc = 0, n;
   always #20 clock = ~clock;
   pipeline_model pipe (.clock(clock), .fire(fire), .pulse(p));
   perf_event_select_decoder DUT (.*, .load_retired(p[10]),
      .load_xlat_miss(p[9]), .load_fault(p[8]), .mm_clear_exec(p[7]),
      .vec_denormal_in(p[6]), .vec_underflow(p[5]), .vector_retired(p[4]),
      .vector_saturating(p[3]), .branch_decoded(p[2]),
      .false_branch_detect(p[1]), .frontend_predict_fix(p[0]),
      .mm_state_dirty(lv[2]), .denormals_as_zero_flag(lv[1]),
      .flush_to_zero_flag(lv[0]));
   task wrap_up;
      begin
         if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task check(input [63:0] nm, input [3:0] seen, input [3:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // select, launch pulses, stop on the answer cycle
   task run(input [7:0] s, input [7:0] u, input [10:0] f, input [2:0] l);
      begin
         @(negedge clock) {event_select, unit_mask, lv} <= {s, u, l};
         fire <= f;
         @(negedge clock) fire <= 11'h000;
         @(negedge clock);
      end
   endtask
   task t_load; begin run(8'hcb, 8'h04, 11'h600, 3'h0);
      check("load", count_increment, 4'h1);
      check("ldpulse", retired_load_xlat_miss, 4'h1);
      run(8'hcb, 8'h04, 11'h700, 3'h0);
      check("fault", count_increment, 4'h0);
      check("ldfault", retired_load_xlat_miss, 4'h0); end endtask
   task t_assist; begin run(8'hcd, 8'h00, 11'h080, 3'h4);
      check("clear", count_increment, 4'h1);
      check("aspulse", vector_assist_count, 4'h1);
      run(8'hcd, 8'h00, 11'h040, 3'h2);
      check("denorm", count_increment, 4'h0);
      run(8'hcd, 8'h00, 11'h020, 3'h0);
      check("under", count_increment, 4'h1); end endtask
   task t_vec; begin run(8'hce, 8'h00, 11'h010, 3'h0);
      check("vecret", count_increment, 4'h1);
      run(8'hcf, 8'h00, 11'h008, 3'h0);
      check("satonly", count_increment, 4'h0);
      check("satpls0", vector_saturating_retired_count, 4'h0);
      run(8'hcf, 8'h00, 11'h018, 3'h0);
      check("sat", count_increment, 4'h1); end endtask
   task t_front; begin run(8'he0, 8'h01, 11'h004, 3'h0);
      check("brdec", count_increment, 4'h1);
      check("brpulse", branch_decoded_count, 4'h1);
      run(8'he4, 8'h01, 11'h002, 3'h0);
      check("false", count_increment, 4'h1);
      check("fbpulse", false_branch_count, 4'h1);
      check("fbredir", frontend_redirect_count, 4'h1);
      check("flush", branch_target_buffer_flush, 4'h1); end endtask
   // stall is sampled from the first cycle after the redirect
   task t_redir; begin run(8'he6, 8'h01, 11'h001, 3'h0);
      check("redir", count_increment, 4'h1);
      n = 0;
      repeat (9) begin n = n + frontend_stall; @(negedge clock); end
      check("stall", n[3:0], 4'h7); end endtask
   task t_none; begin run(8'hff, 8'h00, 11'h7ff, 3'h4);
      check("none", count_increment, 4'h0);
      check("vrpulse", vector_instr_retired_count, 4'h1); end endtask
   // hang guard, the tests need under 100 cycles
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 1000) begin miscompares = miscompares + 1; wrap_up; end
   end
   initial begin
      repeat (10) @(negedge clock);
      rst = 1'b0;
      t_load; t_assist; t_vec; t_front; t_redir; t_none;
      wrap_up;
   end
endmodule // tb
